// ==== pkg/rmc_defines.svh ====
`ifndef RMC_DEFINES_SVH
`define RMC_DEFINES_SVH

// Clock rate in kHz.
`define RMC_CLK_KHZ          25000
// Power-on reset event length in microseconds and its cycle count.
`define RMC_POR_US           100000
`define RMC_POR_CYCLES       ((`RMC_POR_US * `RMC_CLK_KHZ) / 1000)
// Software reset event length in microseconds and its cycle count.
`define RMC_SWR_US           250
`define RMC_SWR_CYCLES       ((`RMC_SWR_US * `RMC_CLK_KHZ) / 1000)
// Command words.
`define RMC_CMD_MODE_NORMAL  16'hd540
`define RMC_CMD_MODE_SENS    16'hd500
`define RMC_CMD_SW_RESET     16'hff00
// Crystal load capacitance code: 0 = 8.5 pF, 15 = 16 pF, 0.5 pF a step.
`define RMC_XLOAD_W          4
`define RMC_XLOAD_RESET      4'h0
// Width of the event counter.
`define RMC_CNT_W            22

`endif

// ==== pkg/rmc_pkg.sv ====
`default_nettype none
package rmc_pkg;
  typedef enum logic [1:0] {
    RMC_ST_POR   = 2'b00,
    RMC_ST_SWR   = 2'b01,
    RMC_ST_RUN   = 2'b10
  } rmc_state_t;
endpackage
`default_nettype wire

// ==== src/rmc_reset_mode_control.sv ====
// Function
// - Reset entered on power-up, glitch while detection armed, or software command.
// - During the power-on event, up to 100 ms, all commands are ignored.
// - Two reset modes exist; sensitive is the default.
// - Normal mode disables power-glitch detection.
// - Every reset event returns configuration, including mode, to defaults.
// - Software reset matches power-on end state but lasts 0.25 ms.
// - Software reset command acts only in sensitive mode.
// - Word D540h selects normal mode; D500h selects sensitive mode.
// - Word FF00h starts a software reset; controller ensures sensitive mode.
// - Crystal load setting covers 8.5 to 16 pF in 0.5 pF steps.
// - After power-on reset, enter sleep and drive the slow clock out.
`timescale 1ns/1ps
`default_nettype none
`include "rmc_defines.svh"

module rmc_reset_mode_control #(
  parameter int POR_CYCLES = `RMC_POR_CYCLES
) (
  // Clock and power-up reset.
  input  wire logic                      clock,
  input  wire logic                      resetn,
  // Analog supply monitor.
  input  wire logic                      glitch_detect,
  // Decoded serial command words.
  input  wire logic                      cmd_valid,
  input  wire logic [15:0]               cmd_word,
  // Crystal load write from the configuration decoder.
  input  wire logic                      xload_we,
  input  wire logic [`RMC_XLOAD_W-1:0]   xload_data,
  // Status and control outputs.
  output logic                           reset_out_n,
  output logic                           cmd_accept,
  output logic                           sensitive_mode,
  output logic                           glitch_armed,
  output logic                           sleep_mode,
  output logic                           slow_clk_sel,
  output logic [`RMC_XLOAD_W-1:0]        xload_code
);

  // Event lengths as counter loads; the counter runs down to zero.
  localparam logic [`RMC_CNT_W-1:0] POR_LOAD = `RMC_CNT_W'(POR_CYCLES - 1);
  localparam logic [`RMC_CNT_W-1:0] SWR_LOAD = `RMC_CNT_W'(`RMC_SWR_CYCLES - 1);

  // Event sequencer state.
  rmc_pkg::rmc_state_t             state;
  rmc_pkg::rmc_state_t             next_state;
  logic [`RMC_CNT_W-1:0]           count;
  logic [`RMC_CNT_W-1:0]           next_count;
  logic                            next_reset_out_n;
  logic                            next_cmd_accept;
  // Next values of the mode flag, the load code and the clock flags.
  logic                            next_sensitive_mode;
  logic                            next_glitch_armed;
  logic [`RMC_XLOAD_W-1:0]         next_xload_code;
  logic                            next_sleep_mode;
  logic                            next_slow_clk_sel;
  // Conditions shared by the groups below.
  logic                            running;
  logic                            cmd_take;
  logic                            glitch_hit;
  logic                            hit_normal;
  logic                            hit_sens;
  logic                            hit_swr;
  logic                            swr_start;

  // One exact-match decoder per reset-related word; a near miss such as a
  // single flipped bit must never change the mode or start an event.
  rmc_word_match #(
    .WORD (`RMC_CMD_MODE_NORMAL)
  ) normal_match_u (
    .word (cmd_word),
    .hit  (hit_normal)
  );
  rmc_word_match #(
    .WORD (`RMC_CMD_MODE_SENS)
  ) sens_match_u (
    .word (cmd_word),
    .hit  (hit_sens)
  );
  rmc_word_match #(
    .WORD (`RMC_CMD_SW_RESET)
  ) swr_match_u (
    .word (cmd_word),
    .hit  (hit_swr)
  );

  // Commands only count while running; inside any event they are dropped.
  assign running    = (state == rmc_pkg::RMC_ST_RUN);
  assign cmd_take   = cmd_valid && running;
  // Detection follows the mode flag, so in normal mode supply spikes are masked.
  assign glitch_hit = glitch_detect && sensitive_mode;
  // The reset word acts only in sensitive mode; a glitch in the same cycle wins.
  assign swr_start  = cmd_take && hit_swr && sensitive_mode && !glitch_hit;

  // Event sequencer: a power-up or glitch event runs the long count, a
  // software reset the short one, and the output is released only at zero.
  always_comb begin
    next_state       = state;
    next_count       = count;
    next_reset_out_n = reset_out_n;
    case (state)
      rmc_pkg::RMC_ST_POR, rmc_pkg::RMC_ST_SWR: begin
        // The reset output stays low for the whole event.
        next_reset_out_n = 1'h0;
        if (glitch_hit) begin
          // A fresh spike restarts the long event instead of being lost.
          next_state = rmc_pkg::RMC_ST_POR;
          next_count = POR_LOAD;
        end else if (count == '0) begin
          next_state       = rmc_pkg::RMC_ST_RUN;
          next_reset_out_n = 1'h1;
        end else begin
          next_count = count - `RMC_CNT_W'(1);
        end
      end
      rmc_pkg::RMC_ST_RUN: begin
        if (glitch_hit) begin
          // A glitch is timed as a full power-on event.
          next_state       = rmc_pkg::RMC_ST_POR;
          next_count       = POR_LOAD;
          next_reset_out_n = 1'h0;
        end else if (swr_start) begin
          next_state       = rmc_pkg::RMC_ST_SWR;
          next_count       = SWR_LOAD;
          next_reset_out_n = 1'h0;
        end
      end
      default: begin
        // An illegal code is handled like power-up, the safest way out.
        next_state       = rmc_pkg::RMC_ST_POR;
        next_count       = POR_LOAD;
        next_reset_out_n = 1'h0;
      end
    endcase
    // Commands are taken again from the first running cycle on.
    next_cmd_accept = (next_state == rmc_pkg::RMC_ST_RUN);
  end

  // Power-up loads the same count as a glitch event, so the parameter alone
  // sets the length of every long event.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state       <= rmc_pkg::RMC_ST_POR;
      count       <= POR_LOAD;
      reset_out_n <= 1'h0;
      cmd_accept  <= 1'h0;
    end else begin
      state       <= next_state;
      count       <= next_count;
      reset_out_n <= next_reset_out_n;
      cmd_accept  <= next_cmd_accept;
    end
  end

  // Reset mode flag: forced to sensitive inside every event, and changed
  // only by an exact mode word while running.
  always_comb begin
    next_sensitive_mode = sensitive_mode;
    if (!running) begin
      next_sensitive_mode = 1'h1;
    end else if (cmd_take && !glitch_hit) begin
      if (hit_normal) begin
        next_sensitive_mode = 1'h0;
      end else if (hit_sens) begin
        next_sensitive_mode = 1'h1;
      end
    end
    // Detection is armed exactly when sensitive mode is in force.
    next_glitch_armed = next_sensitive_mode;
  end

  // Sensitive mode is the power-up default.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sensitive_mode <= 1'h1;
      glitch_armed   <= 1'h1;
    end else begin
      sensitive_mode <= next_sensitive_mode;
      glitch_armed   <= next_glitch_armed;
    end
  end

  // Crystal load code: writes are ignored inside an event, which would
  // otherwise undo the return to defaults.
  always_comb begin
    next_xload_code = xload_code;
    if (!running) begin
      next_xload_code = `RMC_XLOAD_RESET;
    end else if (xload_we) begin
      next_xload_code = xload_data;
    end
  end

  // The load code starts at its lowest setting.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      xload_code <= `RMC_XLOAD_RESET;
    end else begin
      xload_code <= next_xload_code;
    end
  end

  // Clock output control: every event ends in sleep with the slow clock on
  // the clock pin. Leaving sleep belongs to the oscillator control path,
  // so this block only ever sets these two flags.
  always_comb begin
    next_sleep_mode   = sleep_mode;
    next_slow_clk_sel = slow_clk_sel;
    if (!running) begin
      next_sleep_mode   = 1'h1;
      next_slow_clk_sel = 1'h1;
    end
  end

  // Sleep with the slow clock is the power-up state.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sleep_mode   <= 1'h1;
      slow_clk_sel <= 1'h1;
    end else begin
      sleep_mode   <= next_sleep_mode;
      slow_clk_sel <= next_slow_clk_sel;
    end
  end

endmodule

// Exact match of one 16-bit command word; any other word gives no hit.
module rmc_word_match #(
  parameter logic [15:0] WORD = 16'h0000
) (
  // Received word.
  input  wire logic [15:0]  word,
  // Match flag.
  output logic              hit
);

  // A partial match never counts, so all sixteen bits are compared.
  assign hit = (word == WORD);

endmodule

`default_nettype wire

// ==== tb/rmc_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module rmc_assertions (
  // Clock and power-up reset.
  input  wire logic        clock,
  input  wire logic        resetn,
  // Inputs of the block.
  input  wire logic        glitch_detect,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_word,
  // Outputs of the block under watch.
  input  wire logic        reset_out_n,
  input  wire logic        cmd_accept,
  input  wire logic        sensitive_mode,
  input  wire logic        glitch_armed
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // A glitch wins over a word in the same cycle, so such words are left out.
  wire tk  = cmd_valid && cmd_accept && !glitch_detect;
  wire nrm = tk && cmd_word == 16'hd540;
  wire sns = tk && cmd_word == 16'hd500;
  wire swr = tk && cmd_word == 16'hff00;
  a_norm_word: assert property (nrm |=> !sensitive_mode) else $error("norm");
  a_sens_word: assert property (sns |=> sensitive_mode) else $error("sens");
  a_swr_start: assert property (swr && sensitive_mode |=> !reset_out_n) else $error("swr");
  a_swr_normal: assert property (swr && !sensitive_mode |=> reset_out_n) else $error("swr");
  a_other_word: assert property (tk && !nrm && !sns |=> $stable(sensitive_mode))
    else $error("other");
  a_glitch_reset: assert property (glitch_detect && glitch_armed |=> !reset_out_n)
    else $error("glitch");
  a_event_block: assert property (!reset_out_n |-> !cmd_accept) else $error("block");
  a_event_dflt: assert property (!reset_out_n |-> sensitive_mode && glitch_armed)
    else $error("dflt");
  c_swr: cover property (swr && sensitive_mode);
  c_norm: cover property (nrm);
  c_glitch: cover property (glitch_detect && glitch_armed);
endmodule
bind rmc_reset_mode_control rmc_assertions chk_u (.clock, .resetn, .glitch_detect,
  .cmd_valid, .cmd_word, .reset_out_n, .cmd_accept, .sensitive_mode, .glitch_armed);
`default_nettype wire

// ==== tb/rmc_mcu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rmc_mcu_model (
  // Clock.
  input  wire logic   clock,
  // Command word towards the block.
  output logic        cmd_valid,
  output logic [15:0] cmd_word
);
  // Far-side words the block must pass over; the values are arbitrary.
  localparam logic [15:0] AFC_OFF_WORD = 16'h0001;
  localparam logic [15:0] STATUS_WORD  = 16'h0002;
  initial {cmd_valid, cmd_word} = 17'h0;
  // One whole word for one cycle; idle lines show the inverse, so no stale word is reused.
  task automatic send(input logic [15:0] w);
    @(posedge clock) {cmd_valid, cmd_word} <= {1'b1, w};
    @(posedge clock) {cmd_valid, cmd_word} <= {1'b0, ~w};
  endtask
  // An offset read clears the frequency-control enable before the status word.
  task automatic offset_read();
    send(AFC_OFF_WORD);
    send(STATUS_WORD);
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rmc_defines.svh"
module testbench;
  logic        clock = 1'b0, resetn = 1'b0, glitch_detect = 1'b0, xload_we = 1'b0;
  logic        cmd_valid, reset_out_n, cmd_accept, sensitive_mode, glitch_armed;
  logic        sleep_mode, slow_clk_sel;
  logic [15:0] cmd_word;
  logic [3:0]  xload_data = 4'h0, xload_code;
  int          err_count = 0, checks_done = 0, n;
  rmc_reset_mode_control #(.POR_CYCLES(20)) dut_u (.clock, .resetn, .glitch_detect,
    .cmd_valid, .cmd_word, .xload_we, .xload_data, .reset_out_n, .cmd_accept,
    .sensitive_mode, .glitch_armed, .sleep_mode, .slow_clk_sel, .xload_code);
  rmc_mcu_model mcu_u (.clock, .cmd_valid, .cmd_word);
  initial forever #20 clock = ~clock;
  task automatic chk(input string s, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) err_count++;
    if (g !== e) $display("Error %s expected %h seen %h", s, e, g);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Count reset event cycles; one past the bound is a hang.
  task automatic low_len(input int bound);
    for (n = 0; reset_out_n !== 1'b1; n++) begin
      if (n > bound) err_count++;
      if (n > bound) end_sim();
      @(posedge clock) #1;
    end
  endtask
  task automatic cmd(input logic [15:0] w);
    mcu_u.send(w);
    #1;
  endtask
  // One cycle of glitch, or of a load-code write, so one helper serves both.
  task automatic pulse(input logic g, input logic [3:0] v);
    @(posedge clock) {glitch_detect, xload_we, xload_data} <= {g, !g, v};
    @(posedge clock) {glitch_detect, xload_we} <= 2'h0;
    #1;
  endtask
  task automatic t_por();
    chk("dflt", 8'hf0, {sensitive_mode, glitch_armed, sleep_mode, slow_clk_sel, xload_code});
    cmd(16'hd540);
    low_len(300);
    chk("mode", 2'h3, {sensitive_mode, cmd_accept});
    $display("por done");
  endtask
  task automatic t_mode();
    cmd(16'hd540);
    chk("mode", 2'h0, {sensitive_mode, glitch_armed});
    pulse(1'b1, 4'h0);
    chk("rst", 1'h1, reset_out_n);
    cmd(16'hff00);
    chk("rst", 1'h1, reset_out_n);
    cmd(16'hd541);
    chk("sens", 1'h0, sensitive_mode);
    mcu_u.offset_read();
    #1;
    chk("sens", 1'h0, sensitive_mode);
    cmd(16'hd500);
    chk("sens", 1'h1, sensitive_mode);
    $display("mode done");
  endtask
  task automatic t_events();
    pulse(1'b0, 4'hf);
    chk("xload", 4'hf, xload_code);
    cmd(16'hff00);
    low_len(7000);
    chk("swr len", 16'(`RMC_SWR_CYCLES), 16'(n));
    chk("after", 7'h70, {sensitive_mode, cmd_accept, sleep_mode, xload_code});
    pulse(1'b0, 4'h5);
    pulse(1'b1, 4'h5);
    chk("rst", 1'h0, reset_out_n);
    low_len(300);
    chk("xload", 4'h0, xload_code);
    $display("events done");
  endtask
  // A mid-run power-up in normal mode must restore sensitive mode and glitch arming.
  task automatic t_repower();
    cmd(16'hd540);
    chk("sens", 1'h0, sensitive_mode);
    @(posedge clock) resetn <= 1'b0;
    @(posedge clock) resetn <= 1'b1;
    #1;
    chk("repower", 4'hc, {sensitive_mode, glitch_armed, reset_out_n, cmd_accept});
    cmd(16'hd540);
    low_len(300);
    chk("mode", 2'h3, {sensitive_mode, cmd_accept});
    $display("repower done");
  endtask
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    #1;
    t_por();
    t_mode();
    t_events();
    t_repower();
    end_sim();
  end
endmodule
`default_nettype wire
